// *** rtl/cam_result_bus_and_register_set.sv ***
// Result address bus, match flags and register set of one cascaded device
`timescale 1ns/1ps
`include "cam_map.svh"
module cam_result_bus_and_register_set
	import cam_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Cycle control
	input wire logic strobe_n,
	input op_e op,
	input wire logic [3:0] reg_sel,
	input wire logic [2:0] mask_sel,
	input step_e ptr_step,
	input wire logic half_hi,
	input wire loc_t direct_loc,
	input wire logic select_global_n,
	input wire logic select_local_n,
	input wire logic output_en_n,
	// Data bus pins
	input wire logic [31:0] data_bus_in,
	output logic [31:0] data_bus_out,
	output logic data_bus_oe_n,
	// Validity pin
	input wire logic entry_valid_n_in,
	output logic entry_valid_n_out,
	output logic entry_valid_n_oe_n,
	// Result address bus
	output loc_t result_address_bus,
	output logic [3:0] page_number,
	output logic result_address_bus_oe_n,
	// Cascade flags
	input wire logic hit_chain_in_n,
	input wire logic fullness_chain_in_n,
	output logic hit_flag_n,
	output logic multi_hit_flag_n,
	output logic table_full_n
);
	typedef struct packed {
		logic strobe_q;
		word_t key;
		logic [6:0][63:0] mask;
		loc_t ptr;
		logic [2:0] wmask_sel;
		logic [1:0] mode;
		logic lowest;
		logic [3:0] page;
		src_e src;
		loc_t val;
		loc_t bus_q;
		logic [1:0] rtype;
		logic hit;
		logic multi;
		loc_t best;
		logic cmp_pend;
		logic p_hit;
		logic p_multi;
		loc_t p_best;
		logic rd_on;
		logic [31:0] rd_q;
		logic vb_on;
		logic vb_q;
	} st_s;

	st_s st_ff;
	st_s nxt_st;
	cam_if lk();

	cam_array u_array (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.lk(lk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Combinational views

	logic selected;
	logic start;
	logic cmp_op;
	logic mem_op;
	logic wr_mem;
	logic nf_mine;
	logic sys_full_here;
	logic cmp_drive;
	logic drive;
	loc_t cur_loc;
	word_t half_data;
	word_t half_keep;
	word_t sel_mask;
	logic [2:0] wsel;
	logic [31:0] status_word;
	logic [31:0] empty_word;
	logic [31:0] reg_word;

	assign selected = !select_global_n || !select_local_n;
	assign start = st_ff.strobe_q && !strobe_n;
	assign cmp_op = op inside {op_cmp_key, op_cmp_data, op_cmp_data_keep};
	assign mem_op = op inside {op_wr_mem_direct, op_rd_mem_direct, op_wr_mem_ptr, op_rd_mem_ptr};
	assign wr_mem = op inside {op_wr_mem_direct, op_wr_mem_ptr};
	// Only the device with free room and no free room above takes the entry
	assign nf_mine = !fullness_chain_in_n && !lk.all_valid; // [R1] [R22]
	assign sys_full_here = !fullness_chain_in_n && lk.all_valid && st_ff.lowest; // [R2]
	assign cur_loc = (op inside {op_wr_mem_direct, op_rd_mem_direct}) ? direct_loc : st_ff.ptr;
	assign half_data = half_hi ? {data_bus_in, 32'h0000_0000} : {32'h0000_0000, data_bus_in};
	assign half_keep = half_hi ? 64'h0000_0000_ffff_ffff : 64'hffff_ffff_0000_0000;
	// Direct writes use the setup field, every other access the cycle's select
	assign wsel = (op == op_wr_mem_direct) ? st_ff.wmask_sel : mask_sel; // [R16]

	always_comb begin
		sel_mask = '0;
		if (wsel != `NO_MASK) begin
			sel_mask = st_ff.mask[wsel - 3'h1]; // [R14] [R16]
		end
	end

	// Compare ownership resolves through the chain after the strobe rises
	always_comb begin
		cmp_drive = 1'b0;
		if (!st_ff.cmp_pend) begin
			cmp_drive = (st_ff.hit && hit_chain_in_n) || // [R9]
				(!st_ff.hit && hit_chain_in_n && st_ff.lowest);
		end
	end

	assign drive = (st_ff.src == src_fixed) || ((st_ff.src == src_cmp) && cmp_drive);

	////////////////////////////////////////////////////////////////////////////////
	// Register read words

	always_comb begin
		status_word = `WORD_RESET;
		status_word[`STAT_HIT] = !st_ff.hit; // [R18]
		status_word[`STAT_MULTI] = !st_ff.multi; // [R19]
		status_word[`STAT_FULL] = !(lk.all_valid && !fullness_chain_in_n); // [R20]
		status_word[`STAT_TYPE] = st_ff.rtype; // [R21]
		status_word[`STAT_PAGE] = st_ff.page; // [R21]
		status_word[`STAT_LOC] = st_ff.bus_q; // [R11]
		empty_word = `WORD_RESET;
		empty_word[`STAT_PAGE] = st_ff.page; // [R22]
		empty_word[`STAT_LOC] = lk.free_loc; // [R22]
		reg_word = `WORD_RESET;
		if (reg_sel == `SEL_KEY) begin
			reg_word = half_hi ? st_ff.key[63:32] : st_ff.key[31:0];
		end else if (reg_sel <= `SEL_MASK_LAST) begin
			reg_word = half_hi ? st_ff.mask[reg_sel[2:0] - 3'h1][63:32] :
				st_ff.mask[reg_sel[2:0] - 3'h1][31:0];
		end else if (reg_sel == `SEL_POINTER) begin
			reg_word[`STAT_LOC] = st_ff.ptr; // [R15]
		end else if (reg_sel == `SEL_SETUP) begin
			reg_word[`SETUP_WMASK] = st_ff.wmask_sel;
			reg_word[`SETUP_MODE] = st_ff.mode; // [R17]
			reg_word[`SETUP_LOWEST] = st_ff.lowest;
			reg_word[`SETUP_PAGE] = st_ff.page;
		end else if (reg_sel == `SEL_STATUS) begin
			reg_word = status_word;
		end else if (reg_sel == `SEL_EMPTY) begin
			reg_word = empty_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Array port

	always_comb begin
		lk.wr_en = 1'b0;
		lk.wr_addr = cur_loc;
		lk.wr_data = {data_bus_in, data_bus_in};
		lk.wr_mask = sel_mask | half_keep; // [R14]
		lk.wr_valid_n = entry_valid_n_in;
		lk.rd_addr = cur_loc;
		lk.cmp_key = st_ff.key; // [R13]
		lk.cmp_mask = sel_mask | half_keep;
		if (op inside {op_cmp_data, op_cmp_data_keep}) begin
			lk.cmp_key = (st_ff.key & half_keep) | half_data; // [R13]
		end
		if (op == op_wr_next_free) begin
			lk.wr_addr = lk.free_loc;
		end
		// Best-hit read fetches the stored winner, not the pointer location
		if (op == op_rd_best_hit) begin
			lk.rd_addr = st_ff.best; // [R10]
		end
		if (start && selected) begin
			lk.wr_en = wr_mem || (op == op_wr_next_free && nf_mine); // [R1] [R2]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		nxt_st = st_ff;
		nxt_st.strobe_q = strobe_n;
		// Bus is only refreshed while the strobe is high, frozen while low
		if (strobe_n) begin
			nxt_st.bus_q = (st_ff.src == src_cmp && !st_ff.cmp_pend) ? // [R6] [R10]
				(st_ff.hit ? st_ff.best : `LOC_ALL_ONES) : st_ff.val;
		end
		// Flags of a compare show only once its strobe has risen
		if (st_ff.cmp_pend && strobe_n) begin
			nxt_st.cmp_pend = 1'b0; // [R8]
			nxt_st.hit = st_ff.p_hit;
			nxt_st.multi = st_ff.p_multi;
			nxt_st.best = st_ff.p_best;
		end
		if (strobe_n) begin
			nxt_st.rd_on = 1'b0;
			nxt_st.vb_on = 1'b0;
		end
		if (start && selected) begin
			unique case (op)
				op_nop: begin
				end
				op_cmp_key, op_cmp_data, op_cmp_data_keep: begin
					nxt_st.cmp_pend = 1'b1; // [R8]
					nxt_st.p_hit = lk.hit;
					nxt_st.p_multi = lk.multi;
					nxt_st.p_best = lk.best;
					nxt_st.src = src_cmp;
					nxt_st.rtype = `RT_MATCH; // [R25]
					if (op == op_cmp_data_keep) begin
						nxt_st.key = lk.cmp_key; // [R13]
					end
				end
				op_wr_reg: begin
					// Register writes never touch the result bus
					if (reg_sel == `SEL_KEY) begin // [R5]
						nxt_st.key = (st_ff.key & half_keep) | half_data;
					end else if (reg_sel <= `SEL_MASK_LAST) begin
						nxt_st.mask[reg_sel[2:0] - 3'h1] =
							(st_ff.mask[reg_sel[2:0] - 3'h1] & half_keep) | half_data; // [R14]
					end else if (reg_sel == `SEL_POINTER) begin
						nxt_st.ptr = data_bus_in[`STAT_LOC]; // [R15]
					end else if (reg_sel == `SEL_SETUP) begin
						nxt_st.wmask_sel = data_bus_in[`SETUP_WMASK]; // [R16]
						nxt_st.mode = data_bus_in[`SETUP_MODE]; // [R17]
						nxt_st.lowest = data_bus_in[`SETUP_LOWEST];
						nxt_st.page = data_bus_in[`SETUP_PAGE];
					end
				end
				op_rd_reg: begin
					// Status answers only from the bus owner, whether fixed or by compare
					if (reg_sel == `SEL_STATUS) begin
						nxt_st.rd_on = (st_ff.src == src_fixed) ||
							(st_ff.src == src_cmp && cmp_drive); // [R12]
					end else if (reg_sel == `SEL_EMPTY) begin
						nxt_st.rd_on = nf_mine; // [R22]
					end else begin
						nxt_st.rd_on = 1'b1;
					end
					nxt_st.rd_q = reg_word;
				end
				op_wr_mem_direct, op_rd_mem_direct, op_wr_mem_ptr, op_rd_mem_ptr: begin
					// Only the selected device owns the accessed location
					nxt_st.src = src_fixed; // [R3] [R4]
					nxt_st.val = cur_loc;
					nxt_st.rtype = `RT_MEM;
					if (!wr_mem) begin
						nxt_st.rd_on = 1'b1;
						nxt_st.rd_q = half_hi ? lk.rd_data[63:32] : lk.rd_data[31:0];
						nxt_st.vb_on = 1'b1;
						nxt_st.vb_q = lk.rd_valid_n;
					end
					if (op inside {op_wr_mem_ptr, op_rd_mem_ptr}) begin
						if (ptr_step == step_inc) begin
							nxt_st.ptr = st_ff.ptr + 13'h0001; // [R15]
						end else if (ptr_step == step_dec) begin
							nxt_st.ptr = st_ff.ptr - 13'h0001; // [R15]
						end
					end
				end
				op_wr_next_free: begin
					nxt_st.rtype = `RT_MEM;
					if (nf_mine) begin
						nxt_st.src = src_fixed; // [R1]
						nxt_st.val = lk.free_loc;
					end else if (sys_full_here) begin
						nxt_st.src = src_fixed; // [R2]
						nxt_st.val = `LOC_ALL_ONES;
					end else begin
						nxt_st.src = src_none; // [R1]
					end
				end
				op_rd_best_hit: begin
					// Reuses the stored compare, no fresh search
					nxt_st.src = src_cmp; // [R10]
					nxt_st.rtype = `RT_MATCH;
					nxt_st.rd_on = cmp_drive && st_ff.hit;
					nxt_st.rd_q = half_hi ? lk.rd_data[63:32] : lk.rd_data[31:0];
				end
				op_ptr_inc: begin
					nxt_st.ptr = st_ff.ptr + 13'h0001; // [R15]
				end
				op_ptr_dec: begin
					nxt_st.ptr = st_ff.ptr - 13'h0001; // [R15]
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
			st_ff.strobe_q <= 1'b1;
			st_ff.key <= `KEY_RESET;
			st_ff.ptr <= `LOC_RESET;
			st_ff.src <= src_none;
			st_ff.val <= `LOC_RESET;
			st_ff.bus_q <= `LOC_RESET;
			st_ff.rtype <= `RT_RESET;
			st_ff.rd_q <= `WORD_RESET;
			st_ff.vb_q <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pins

	// Enable is gated straight from the pin, independent of the strobe
	assign result_address_bus_oe_n = !(drive && !output_en_n); // [R7] [R4]
	assign result_address_bus = st_ff.bus_q;
	assign page_number = st_ff.page;
	assign data_bus_out = st_ff.rd_q;
	assign data_bus_oe_n = !st_ff.rd_on;
	assign entry_valid_n_out = st_ff.vb_q;
	assign entry_valid_n_oe_n = !st_ff.vb_on;
	// Cascade flags follow the chain combinationally once settled
	assign hit_flag_n = hit_chain_in_n && !st_ff.hit; // [R8]
	assign multi_hit_flag_n = !(st_ff.multi || (st_ff.hit && !hit_chain_in_n)); // [R8]
	assign table_full_n = !(lk.all_valid && !fullness_chain_in_n); // [R20]
endmodule // cam_result_bus_and_register_set

// *** rtl/cam_map.svh ***
// Register selects, field positions and reset values of the lookup device
// Functional notes
// R1 - Next-free write: only storing device drives bus
// R2 - System full: lowest device drives all ones
// R3 - Random access: only accessed device drives bus
// R4 - Broadcast write: every enabled device drives bus
// R5 - Non-address cycles leave result bus unchanged
// R6 - Bus changes only while strobe high
// R7 - Output enable asynchronous, tri-states bus when high
// R8 - Match flags settle after strobe rises
// R9 - Compare may precede late output enable
// R10 - Best-hit read restores match address from flags
// R11 - Status low bits mirror result bus
// R12 - Status read answered by owning device
// R13 - Compare uses key or data, optionally stored
// R14 - Seven masks; high bit excludes bit
// R15 - Pointer low thirteen bits, step modes
// R16 - Setup field picks direct-write mask, zero none
// R17 - Setup holds mode, lowest marker, page
// R18 - Status bit 30 is active-low hit
// R19 - Status bit 29 is local multi-hit
// R20 - Status bit 28 low when full and chained
// R21 - Status holds type, page, location; reserved zero
// R22 - Empty-slot register answered by first free device
// R23 - Validity bit high means empty, skipped
// R24 - Location zero has highest priority
// R25 - Fixed distinct result-type codes
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH
`define SEL_KEY 4'h0
`define SEL_MASK_LAST 4'h7
`define SEL_POINTER 4'h8
`define SEL_SETUP 4'h9
`define SEL_STATUS 4'ha
`define SEL_EMPTY 4'hb
`define SETUP_WMASK 31:29
`define SETUP_MODE 27:26
`define SETUP_LOWEST 25
`define SETUP_PAGE 3:0
`define STAT_HIT 30
`define STAT_MULTI 29
`define STAT_FULL 28
`define STAT_TYPE 25:24
`define STAT_PAGE 19:16
`define STAT_LOC 12:0
`define RT_RESET 2'h0
`define RT_MATCH 2'h1
`define RT_MEM 2'h2
`define LOC_ALL_ONES 13'h1fff
`define LOC_RESET 13'h0000
`define WORD_RESET 32'h0000_0000
`define KEY_RESET 64'h0000_0000_0000_0000
`define NO_MASK 3'h0
`endif

// *** rtl/cam_pkg.sv ***
// Types shared by the lookup device modules
package cam_pkg;
	typedef logic [12:0] loc_t;
	typedef logic [63:0] word_t;
	typedef enum logic [3:0] {
		op_nop, op_cmp_key, op_cmp_data, op_cmp_data_keep, op_wr_reg, op_rd_reg,
		op_wr_mem_direct, op_rd_mem_direct, op_wr_mem_ptr, op_rd_mem_ptr,
		op_wr_next_free, op_rd_best_hit, op_ptr_inc, op_ptr_dec
	} op_e;
	typedef enum logic [1:0] {step_none, step_inc, step_dec} step_e;
	typedef enum logic [1:0] {src_none, src_fixed, src_cmp} src_e;
endpackage

// *** rtl/cam_if.sv ***
// Link between the control logic and the lookup array
`timescale 1ns/1ps
interface cam_if;
	import cam_pkg::*;
	logic wr_en;
	loc_t wr_addr;
	word_t wr_data;
	word_t wr_mask;
	logic wr_valid_n;
	loc_t rd_addr;
	word_t rd_data;
	logic rd_valid_n;
	word_t cmp_key;
	word_t cmp_mask;
	logic hit;
	logic multi;
	loc_t best;
	loc_t free_loc;
	logic all_valid;
	modport ctl(output wr_en, wr_addr, wr_data, wr_mask, wr_valid_n, rd_addr, cmp_key, cmp_mask,
		input rd_data, rd_valid_n, hit, multi, best, free_loc, all_valid);
	modport mem(input wr_en, wr_addr, wr_data, wr_mask, wr_valid_n, rd_addr, cmp_key, cmp_mask,
		output rd_data, rd_valid_n, hit, multi, best, free_loc, all_valid);
endinterface // cam_if

// *** rtl/cam_array.sv ***
// Lookup array: storage, validity, compare and first-free search
`timescale 1ns/1ps
module cam_array
	import cam_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Control side
	cam_if.mem lk
);
	localparam int DEPTH = 8192;
	word_t mem [DEPTH];
	logic [DEPTH-1:0] empty_ff;

	// Masked write keeps excluded bits; storage carries no reset on purpose
	always_ff @(posedge clk_sys) begin
		if (lk.wr_en) begin
			mem[lk.wr_addr] <= (mem[lk.wr_addr] & lk.wr_mask) | (lk.wr_data & ~lk.wr_mask); // [R14]
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			empty_ff <= '1;
		end else if (lk.wr_en) begin
			empty_ff[lk.wr_addr] <= lk.wr_valid_n; // [R23]
		end
	end

	assign lk.rd_data = mem[lk.rd_addr];
	assign lk.rd_valid_n = empty_ff[lk.rd_addr];
	assign lk.all_valid = ~|empty_ff;

	// Scan downward so the lowest index wins
	always_comb begin
		lk.hit = 1'b0;
		lk.multi = 1'b0;
		lk.best = '0;
		lk.free_loc = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (!empty_ff[i] && ((mem[i] ^ lk.cmp_key) & ~lk.cmp_mask) == '0) begin // [R23]
				lk.multi = lk.multi | lk.hit;
				lk.hit = 1'b1;
				lk.best = loc_t'(i); // [R24]
			end
			if (empty_ff[i]) begin
				lk.free_loc = loc_t'(i); // [R24]
			end
		end
	end
endmodule // cam_array

// *** tb/cam_upper_neighbour.sv ***
// Higher-priority cascade neighbour and pull-up on the result bus wire
`timescale 1ns/1ps
module cam_upper_neighbour
	import cam_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Neighbour state
	input wire logic hit_above,
	input wire logic room_above,
	// Chain into the device
	output logic hit_chain_in_n,
	output logic fullness_chain_in_n,
	// Result bus wire
	input wire loc_t result_address_bus,
	input wire logic result_address_bus_oe_n,
	output loc_t bus_wire
);
	logic [1:0] hit_ripple_ff;
	logic [1:0] room_ripple_ff;
	// Chain ripples through two stages, so the device learns of the neighbour late
	always_ff @(posedge clk_sys) begin
		hit_ripple_ff <= {hit_ripple_ff[0], hit_above};
		room_ripple_ff <= {room_ripple_ff[0], room_above};
	end
	assign hit_chain_in_n = !hit_ripple_ff[1];
	// Chain goes low when nothing above has room left
	assign fullness_chain_in_n = room_ripple_ff[1];
	// Pull-up: a released bus reads all ones, never the last value
	assign bus_wire = result_address_bus_oe_n ? 13'h1fff : result_address_bus;
endmodule // cam_upper_neighbour

// *** tb/cam_result_bus_properties.sv ***
// Concurrent checks on the result bus, flags and data bus enable
`timescale 1ns/1ps
module cam_result_bus_properties
	import cam_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Cycle control
	input wire logic strobe_n,
	input op_e op,
	input wire logic [3:0] reg_sel,
	input wire logic select_global_n,
	input wire logic select_local_n,
	input wire logic output_en_n,
	// Outputs
	input logic data_bus_oe_n,
	input loc_t result_address_bus,
	input logic result_address_bus_oe_n,
	// Cascade
	input wire logic hit_chain_in_n,
	input wire logic fullness_chain_in_n,
	input logic hit_flag_n,
	input logic multi_hit_flag_n,
	input logic table_full_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic sel;
	assign sel = !select_global_n || !select_local_n;
	a_enable_high_tristate: assert property (output_en_n |-> result_address_bus_oe_n)
		else $error("result bus driven with enable high");
	a_bus_latched_low: assert property (!strobe_n |=> $stable(result_address_bus))
		else $error("result bus moved while strobe low");
	a_flags_hold_low: assert property (!strobe_n && !$past(strobe_n) && !$past(strobe_n, 2)
		&& $stable(hit_chain_in_n) |-> $stable(hit_flag_n) && $stable(multi_hit_flag_n))
		else $error("match flags moved while strobe low");
	a_bus_owner_steady: assert property (!strobe_n && !$past(strobe_n) && !$past(strobe_n, 2)
		&& $stable(output_en_n) && $stable(hit_chain_in_n) && $stable(fullness_chain_in_n)
		|-> $stable(result_address_bus_oe_n)) else $error("bus enable moved while strobe low");
	a_full_needs_chain: assert property (fullness_chain_in_n |-> table_full_n)
		else $error("full flag low with chain input high");
	a_reset_state_clean: assert property ($rose(rst_b) |-> result_address_bus == 13'h0000
		&& result_address_bus_oe_n && hit_flag_n) else $error("bad state after reset");
	a_setup_read_answer: assert property (!strobe_n && $past(strobe_n) && sel && op == op_rd_reg
		&& reg_sel == 4'h9 |=> !data_bus_oe_n) else $error("setup read not answered");
	a_deselected_silent: assert property (!strobe_n && $past(strobe_n) && !sel
		|=> data_bus_oe_n [*2]) else $error("unselected device drove data bus");
	a_release_after_high: assert property (strobe_n |=> data_bus_oe_n)
		else $error("data bus held after strobe high");
endmodule // cam_result_bus_properties
bind cam_result_bus_and_register_set cam_result_bus_properties i_props (
	.clk_sys(clk_sys), .rst_b(rst_b), .strobe_n(strobe_n), .op(op), .reg_sel(reg_sel),
	.select_global_n(select_global_n), .select_local_n(select_local_n),
	.output_en_n(output_en_n), .data_bus_oe_n(data_bus_oe_n),
	.result_address_bus(result_address_bus), .result_address_bus_oe_n(result_address_bus_oe_n),
	.hit_chain_in_n(hit_chain_in_n), .fullness_chain_in_n(fullness_chain_in_n),
	.hit_flag_n(hit_flag_n), .multi_hit_flag_n(multi_hit_flag_n), .table_full_n(table_full_n)
);

// *** tb/cam_result_bus_and_register_set_test.sv ***
// Self-checking bench for the result bus and register set
`timescale 1ns/1ps
module cam_result_bus_and_register_set_test;
	import cam_pkg::*;
	logic clk_sys, rst_b, strobe_n, half_hi, select_global_n, select_local_n, output_en_n;
	logic entry_valid_n_in, hit_above, room_above, data_bus_oe_n, rd_oe_n, entry_valid_n_out;
	logic entry_valid_n_oe_n, result_address_bus_oe_n, hit_chain_in_n, fullness_chain_in_n;
	logic hit_flag_n, multi_hit_flag_n, table_full_n;
	logic [3:0] reg_sel, page_number;
	logic [2:0] mask_sel;
	logic [31:0] data_bus_in, data_bus_out, rd;
	op_e op;
	step_e ptr_step;
	loc_t direct_loc, result_address_bus, bus_wire;
	int fail_count, total_checks;

	cam_result_bus_and_register_set i_cam_result_bus_and_register_set (.*);
	cam_upper_neighbour i_cam_upper_neighbour (.clk_sys(clk_sys), .hit_above(hit_above),
		.room_above(room_above), .hit_chain_in_n(hit_chain_in_n),
		.fullness_chain_in_n(fullness_chain_in_n), .result_address_bus(result_address_bus),
		.result_address_bus_oe_n(result_address_bus_oe_n), .bus_wire(bus_wire));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Flags and bus wire together, as the far side sees them
	task chk_bus(input string n, input logic [1:0] f, input loc_t b);
		chk(n, {17'h0, f, b}, {17'h0, hit_flag_n, multi_hit_flag_n, bus_wire});
	endtask
	// One strobed cycle; strobe goes high again so the next cycle is a fresh take
	task cyc(input op_e o, input logic [3:0] s, input logic h, input loc_t l, input logic [31:0] d);
		@(posedge clk_sys);
		op <= o;
		reg_sel <= s;
		half_hi <= h;
		direct_loc <= l;
		data_bus_in <= d;
		strobe_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 rd = data_bus_out;
		rd_oe_n = data_bus_oe_n;
		@(posedge clk_sys);
		strobe_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end
	initial begin
		{strobe_n, select_global_n, select_local_n, output_en_n, entry_valid_n_in} = 5'h18;
		{hit_above, room_above, half_hi, rst_b} = 4'h0;
		op = op_nop;
		ptr_step = step_none;
		{reg_sel, mask_sel, direct_loc, data_bus_in} = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1 chk_bus("reset state", 2'b11, 13'h1fff);
		cyc(op_wr_reg, 4'h9, 1'b0, 13'h0, 32'h0200_0005);
		cyc(op_rd_reg, 4'h9, 1'b0, 13'h0, 32'h0);
		chk("setup", 32'h0200_0005, rd);
		chk("page pin", 32'h5, {28'h0, page_number});
		chk("full pin", 32'h1, {31'h0, table_full_n});
		cyc(op_rd_reg, 4'ha, 1'b0, 13'h0, 32'h0);
		chk("status reset", 32'h7005_0000, rd);
		cyc(op_wr_reg, 4'h0, 1'b0, 13'h0, 32'h1234_5678);
		cyc(op_wr_reg, 4'h0, 1'b1, 13'h0, 32'h0);
		cyc(op_wr_mem_direct, 4'h0, 1'b0, 13'h3, 32'h1234_5678);
		cyc(op_wr_mem_direct, 4'h0, 1'b1, 13'h3, 32'h0);
		cyc(op_wr_mem_direct, 4'h0, 1'b0, 13'h9, 32'hdead_beef);
		cyc(op_wr_mem_direct, 4'h0, 1'b1, 13'h9, 32'h0);
		chk_bus("write location", 2'b11, 13'h9);
		cyc(op_rd_reg, 4'ha, 1'b0, 13'h0, 32'h0);
		chk("status access", 32'h7205_0009, rd);
		@(posedge clk_sys) output_en_n <= 1'b1;
		@(posedge clk_sys) #1 chk_bus("enable high", 2'b11, 13'h1fff);
		@(posedge clk_sys) output_en_n <= 1'b0;
		cyc(op_wr_reg, 4'h8, 1'b0, 13'h0, 32'h7);
		chk_bus("register write", 2'b11, 13'h9);
		cyc(op_ptr_inc, 4'h0, 1'b0, 13'h0, 32'h0);
		cyc(op_rd_reg, 4'h8, 1'b0, 13'h0, 32'h0);
		chk("pointer", 32'h8, rd);
		@(posedge clk_sys) select_local_n <= 1'b1;
		cyc(op_rd_mem_direct, 4'h0, 1'b0, 13'h5, 32'h0);
		chk_bus("unselected read", 2'b11, 13'h9);
		chk("unselected drive", 32'h1, {31'h0, rd_oe_n});
		@(posedge clk_sys) select_local_n <= 1'b0;
		cyc(op_cmp_key, 4'h0, 1'b0, 13'h0, 32'h0);
		chk_bus("compare", 2'b01, 13'h3);
		cyc(op_wr_reg, 4'h0, 1'b0, 13'h0, 32'hdead_beef);
		chk_bus("key write after compare", 2'b01, 13'h3);
		cyc(op_rd_mem_direct, 4'h0, 1'b0, 13'h9, 32'h0);
		chk("array read", 32'hdead_beef, rd);
		chk("validity pin", 32'h2, {30'h0, entry_valid_n_oe_n, entry_valid_n_out});
		chk_bus("read location", 2'b01, 13'h9);
		cyc(op_rd_best_hit, 4'h0, 1'b0, 13'h0, 32'h0);
		chk_bus("best hit restore", 2'b01, 13'h3);
		chk("best hit data", 32'h1234_5678, rd);
		cyc(op_cmp_key, 4'h0, 1'b0, 13'h0, 32'h0);
		chk_bus("second key", 2'b01, 13'h9);
		cyc(op_wr_reg, 4'h1, 1'b0, 13'h0, 32'hffff_ffff);
		@(posedge clk_sys) mask_sel <= 3'h1;
		cyc(op_cmp_key, 4'h0, 1'b0, 13'h0, 32'h0);
		chk_bus("masked compare", 2'b00, 13'h3);
		cyc(op_rd_reg, 4'ha, 1'b0, 13'h0, 32'h0);
		chk("status match", 32'h1105_0003, rd);
		@(posedge clk_sys) mask_sel <= 3'h0;
		cyc(op_wr_reg, 4'h0, 1'b0, 13'h0, 32'h5555_5555);
		cyc(op_cmp_key, 4'h0, 1'b0, 13'h0, 32'h0);
		chk_bus("no match", 2'b11, 13'h1fff);
		@(posedge clk_sys) hit_above <= 1'b1;
		cyc(op_wr_reg, 4'h0, 1'b0, 13'h0, 32'h1234_5678);
		cyc(op_cmp_key, 4'h0, 1'b0, 13'h0, 32'h0);
		chk("higher hit bus", 32'h1fff, {19'h0, bus_wire});
		cyc(op_rd_reg, 4'ha, 1'b0, 13'h0, 32'h0);
		chk("status not owner", 32'h1, {31'h0, rd_oe_n});
		@(posedge clk_sys) hit_above <= 1'b0;
		cyc(op_wr_next_free, 4'h0, 1'b0, 13'h0, 32'haaaa_aaaa);
		chk("next free bus", 32'h0, {19'h0, bus_wire});
		cyc(op_rd_reg, 4'hb, 1'b0, 13'h0, 32'h0);
		chk("empty slot", 32'h0005_0001, rd);
		@(posedge clk_sys) room_above <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cyc(op_wr_next_free, 4'h0, 1'b0, 13'h0, 32'haaaa_aaaa);
		chk("next free elsewhere", 32'h1fff, {19'h0, bus_wire});
		cyc(op_rd_reg, 4'hb, 1'b0, 13'h0, 32'h0);
		chk("empty slot silent", 32'h1, {31'h0, rd_oe_n});
		cyc(op_rd_reg, 4'ha, 1'b0, 13'h0, 32'h0);
		chk("status after foreign write", 32'h1, {31'h0, rd_oe_n});
		report_and_stop();
	end
endmodule // cam_result_bus_and_register_set_test
